// File: verilog/segment_lcd_driver.sv
// Segment LCD driver: pattern entries, pointer access and panel scan
module segment_lcd_driver
	import segment_lcd_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_slow_tick,
	input wire logic [1:0] i_freq_select,
	input wire logic i_hold,
	input wire logic i_display_on_instruction,
	input wire logic i_display_off_instruction,
	input wire logic i_load_pointer_low_part,
	input wire logic i_load_pointer_high_part,
	input wire logic i_write_entry,
	input wire logic i_read_entry,
	input wire logic [3:0] i_nibble,
	output logic [3:0] o_read_nibble,
	output logic o_read_valid,
	output logic [5:0] o_pattern_ram_pointer,
	output logic o_display_enabled,
	output logic o_frame_polarity,
	output logic [7:0] o_common_level,
	output logic [63:0] o_segment_level
);
	// ===========================================================================
	// Declarations
	// ===========================================================================
	// Pattern storage and its indirect pointer
	logic [NIBBLE_WIDTH-1:0] segment_pattern_ram [SEGMENT_COUNT]; // Pattern entries
	logic [POINTER_WIDTH-1:0] pointer_reg; // Indirect address pointer
	logic [POINTER_WIDTH-1:0] pointer_next;
	// Control and scan state
	logic display_reg; // Panel drive enabled
	logic display_next;
	logic [1:0] slot_reg; // Active common slot
	logic [1:0] slot_next;
	logic polarity_reg; // Frame inversion phase
	logic polarity_next;
	// Indirect read answer
	logic [3:0] read_nibble_reg; // Value returned by an indirect read
	logic [3:0] read_nibble_next;
	logic read_valid_reg; // One-cycle read answer marker
	logic read_valid_next;
	// Registered panel levels, two bits per line
	logic [7:0] common_reg; // Registered common drive levels
	logic [7:0] common_next;
	logic [63:0] segment_reg; // Registered segment drive levels
	logic [63:0] segment_next;
	// Divider output and pointer decode
	logic scan_tick; // One pulse per alternating frequency period
	logic pointer_in_range; // Pointer names a real entry
	logic [4:0] entry_index; // Low five pointer bits

	// ===========================================================================
	// Scan divider
	// ===========================================================================
	// Counts slow ticks and pulses once per alternating period
	alternating_frequency_divider u_divider (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_slow_tick(i_slow_tick),
		.i_freq_select(i_freq_select),
		.o_scan_tick(scan_tick)
	);

	// ===========================================================================
	// Drive level functions
	// ===========================================================================
	// Level codes name the four bias rails. A dot sees the gap between its
	// common and its segment: a selected common against a lit segment spans
	// all three steps, every other pairing spans one step and stays dark.
	// The phase flips once per frame so no cell is left with a net DC bias.
	// Level for a common line in the current slot and phase
	function automatic logic [1:0] common_level(input logic selected, input logic phase);
		if (selected) begin
			common_level = phase ? LEVEL_V0 : LEVEL_V3;
		end else begin
			common_level = phase ? LEVEL_V2 : LEVEL_V1;
		end
	endfunction

	// Level for a segment line, lit means opposite of the selected common
	// An unlit segment sits one step from the selected common
	function automatic logic [1:0] segment_level(input logic lit, input logic phase);
		if (lit) begin
			segment_level = phase ? LEVEL_V3 : LEVEL_V0;
		end else begin
			segment_level = phase ? LEVEL_V1 : LEVEL_V2;
		end
	endfunction

	// ===========================================================================
	// Pointer and instruction decode
	// ===========================================================================
	// Pointers from 20h up name no entry; bit five alone marks them
	assign pointer_in_range = (pointer_reg <= LAST_ENTRY_ADDRESS);
	assign entry_index = pointer_reg[4:0];

	// Next pointer value from the two load instructions
	// Both loads may come in one cycle; each only touches its own bits
	always_comb begin
		pointer_next = pointer_reg;
		if (i_load_pointer_low_part) begin
			pointer_next[POINTER_LOW_MSB:0] = i_nibble;
		end
		if (i_load_pointer_high_part) begin
			// Upper two nibble bits have no pointer bits to land in
			pointer_next[POINTER_WIDTH-1:POINTER_HIGH_LSB] = i_nibble[1:0];
		end
	end

	// Indirect read returns the pointed entry one cycle later
	// The answer marker stands one cycle; the nibble holds until the next read
	always_comb begin
		read_nibble_next = read_nibble_reg;
		read_valid_next = 1'b0;
		if (i_read_entry) begin
			read_valid_next = 1'b1;
			// Addresses past the last entry read as zero
			read_nibble_next = pointer_in_range ? segment_pattern_ram[entry_index]
				: ENTRY_RESET;
		end
	end

	// Display on and off; hold does not stop the panel
	// Hold is not read on purpose: the panel keeps scanning while the core sleeps
	always_comb begin
		display_next = display_reg;
		if (i_display_off_instruction) begin
			display_next = 1'b0;
		end else if (i_display_on_instruction) begin
			display_next = 1'b1;
		end
	end

	// ===========================================================================
	// Pattern storage
	// ===========================================================================
	// Indirect write; out of range pointer writes are dropped
	// A load in the same cycle only moves the pointer after this write
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			for (int k = 0; k < SEGMENT_COUNT; k++) begin
				segment_pattern_ram[k] <= ENTRY_RESET;
			end
		end else if (i_write_entry && pointer_in_range) begin
			segment_pattern_ram[entry_index] <= i_nibble;
		end
	end

	// ===========================================================================
	// Scan sequencing
	// ===========================================================================
	// Step the common slot per scan tick, flip polarity per frame
	// Slot and phase run even while the display is off, so switching on
	// resumes mid-frame with a consistent phase
	always_comb begin
		slot_next = slot_reg;
		polarity_next = polarity_reg;
		if (scan_tick) begin
			slot_next = slot_reg + 2'h1;
			if (slot_reg == SLOT_LAST) begin
				polarity_next = ~polarity_reg;
			end
		end
	end

	// Drive levels for the panel from the entries and the slot
	always_comb begin
		common_next = '0;
		segment_next = '0;
		if (display_reg) begin
			// Common n is selected in slot n
			for (int n = 0; n < COMMON_COUNT; n++) begin
				common_next[n*LEVEL_WIDTH +: LEVEL_WIDTH] =
					common_level(slot_reg == n[1:0], polarity_reg);
			end
			// Entry k bit n lights segment k in slot n
			for (int k = 0; k < SEGMENT_COUNT; k++) begin
				segment_next[k*LEVEL_WIDTH +: LEVEL_WIDTH] =
					segment_level(segment_pattern_ram[k][slot_reg], polarity_reg);
			end
		end
		// When off, every line rests at V0 so no dot sees a voltage
	end

	// ===========================================================================
	// State registers
	// ===========================================================================
	// Register control state and outputs
	// Reset is synchronous; every register clears on a rising clock edge while i_rstn is low
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			pointer_reg <= POINTER_RESET;
			display_reg <= 1'b0;
			slot_reg <= SLOT_RESET;
			polarity_reg <= 1'b0;
			read_nibble_reg <= ENTRY_RESET;
			read_valid_reg <= 1'b0;
			common_reg <= '0;
			segment_reg <= '0;
		end else begin
			pointer_reg <= pointer_next;
			display_reg <= display_next;
			slot_reg <= slot_next;
			polarity_reg <= polarity_next;
			read_nibble_reg <= read_nibble_next;
			read_valid_reg <= read_valid_next;
			common_reg <= common_next;
			segment_reg <= segment_next;
		end
	end

	// Outputs straight from flip-flops
	// Panel levels trail the slot and display registers by one edge
	assign o_read_nibble = read_nibble_reg;
	assign o_read_valid = read_valid_reg;
	assign o_pattern_ram_pointer = pointer_reg;
	assign o_display_enabled = display_reg;
	assign o_frame_polarity = polarity_reg;
	assign o_common_level = common_reg;
	assign o_segment_level = segment_reg;
endmodule

// File: verilog/segment_lcd_pkg.sv
// Constants, level codes and the scan divider for the segment LCD driver
// ===========================================================================
// ===========================================================================
package segment_lcd_pkg;
	// Panel geometry
	localparam int SEGMENT_COUNT = 32;
	localparam int COMMON_COUNT = 4;
	localparam int NIBBLE_WIDTH = 4;
	localparam int POINTER_WIDTH = 6;
	localparam int LEVEL_WIDTH = 2;
	// Pointer fields
	localparam int POINTER_LOW_MSB = 3;
	localparam int POINTER_HIGH_LSB = 4;
	localparam logic [POINTER_WIDTH-1:0] POINTER_RESET = 6'h00;
	localparam logic [POINTER_WIDTH-1:0] LAST_ENTRY_ADDRESS = 6'h1F;
	localparam logic [NIBBLE_WIDTH-1:0] ENTRY_RESET = 4'h0;
	// Drive level codes, index into the four bias rails V0..V3
	localparam logic [1:0] LEVEL_V0 = 2'h0;
	localparam logic [1:0] LEVEL_V1 = 2'h1;
	localparam logic [1:0] LEVEL_V2 = 2'h2;
	localparam logic [1:0] LEVEL_V3 = 2'h3;
	// Divider select codes
	localparam logic [1:0] SELECT_DIV64 = 2'h0;
	localparam logic [1:0] SELECT_DIV128 = 2'h1;
	localparam logic [1:0] SELECT_DIV256 = 2'h2;
	localparam logic [1:0] SELECT_DIV512 = 2'h3;
	localparam int DIVIDER_WIDTH = 9;
	localparam logic [DIVIDER_WIDTH-1:0] DIV64_LAST = 9'h03F;
	localparam logic [DIVIDER_WIDTH-1:0] DIV128_LAST = 9'h07F;
	localparam logic [DIVIDER_WIDTH-1:0] DIV256_LAST = 9'h0FF;
	localparam logic [DIVIDER_WIDTH-1:0] DIV512_LAST = 9'h1FF;
	localparam logic [DIVIDER_WIDTH-1:0] DIVIDER_RESET = 9'h000;
	localparam logic [1:0] SLOT_RESET = 2'h0;
	localparam logic [1:0] SLOT_LAST = 2'h3;
endpackage

// ===========================================================================
// Alternating frequency divider: slow clock ticks in, one scan tick out
// ===========================================================================
module alternating_frequency_divider
	import segment_lcd_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_slow_tick,
	input wire logic [1:0] i_freq_select,
	output logic o_scan_tick
);
	logic [DIVIDER_WIDTH-1:0] count_reg; // Slow ticks seen in this period
	logic [DIVIDER_WIDTH-1:0] count_next;
	logic tick_reg; // Registered scan tick
	logic tick_next;
	logic [DIVIDER_WIDTH-1:0] last_count; // Terminal count for the ratio

	// Pick the terminal count from the two-bit select
	always_comb begin
		unique case (i_freq_select)
			SELECT_DIV64: last_count = DIV64_LAST;
			SELECT_DIV128: last_count = DIV128_LAST;
			SELECT_DIV256: last_count = DIV256_LAST;
			SELECT_DIV512: last_count = DIV512_LAST;
		endcase
	end

	// Count slow ticks, wrap and pulse at the terminal count
	always_comb begin
		count_next = count_reg;
		tick_next = 1'b0;
		if (i_slow_tick) begin
			if (count_reg >= last_count) begin
				// Also recovers when the ratio shrinks mid-period
				count_next = DIVIDER_RESET;
				tick_next = 1'b1;
			end else begin
				count_next = count_reg + 9'h001;
			end
		end
	end

	// Register divider state
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			count_reg <= DIVIDER_RESET;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_reg <= tick_next;
		end
	end

	assign o_scan_tick = tick_reg;
endmodule

// File: sim/segment_lcd_asserts.sv
// Port-level checks for the segment LCD driver
module segment_lcd_asserts
	import segment_lcd_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_display_on_instruction,
	input wire logic i_display_off_instruction,
	input wire logic i_load_pointer_low_part,
	input wire logic i_load_pointer_high_part,
	input wire logic i_read_entry,
	input wire logic [3:0] i_nibble,
	input wire logic o_read_valid,
	input wire logic [5:0] o_pattern_ram_pointer,
	input wire logic o_display_enabled,
	input wire logic [7:0] o_common_level,
	input wire logic [63:0] o_segment_level
);
	timeunit 1ns;
	timeprecision 1ns;
	// ===========================================================
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	// Display has been off for two edges, so levels have caught up
	sequence off_settled_s;
		!o_display_enabled [*2];
	endsequence
	read_answer_a: assert property (i_read_entry |=> o_read_valid)
		else $error("read not answered");
	valid_cause_a: assert property (o_read_valid |-> $past(i_read_entry))
		else $error("read answer without request");
	low_load_a: assert property (i_load_pointer_low_part |=>
		o_pattern_ram_pointer[3:0] == $past(i_nibble))
		else $error("pointer low part wrong");
	high_load_a: assert property (i_load_pointer_high_part |=>
		o_pattern_ram_pointer[5:4] == $past(i_nibble[1:0]))
		else $error("pointer high part wrong");
	off_wins_a: assert property (i_display_off_instruction |=> !o_display_enabled)
		else $error("display not switched off");
	on_enables_a: assert property (i_display_on_instruction &&
		!i_display_off_instruction |=> o_display_enabled)
		else $error("display not switched on");
	blank_off_a: assert property (off_settled_s |->
		o_segment_level == 64'h0 && o_common_level == 8'h00)
		else $error("levels driven while off");
	one_common_a: assert property (o_display_enabled [*2] ##0
		o_common_level[1:0] == 2'h3 |-> o_common_level[7:2] == 6'h15)
		else $error("more than one common selected");
endmodule

// File: sim/lcd_glass_model.sv
// Passive glass: a dot shows only when its cell sees the full drive
module lcd_glass_model
	import segment_lcd_pkg::*;
(
	input wire logic [7:0] i_common_level,
	input wire logic [63:0] i_segment_level,
	output logic [127:0] o_dot_lit
);
	timeunit 1ns;
	timeprecision 1ns;
	// Dot 4k+n lights when common n and segment k sit on opposite outer rails
	always_comb begin
		for (int k = 0; k < 32; k++) begin
			for (int n = 0; n < 4; n++) begin
				o_dot_lit[k*4+n] = (i_common_level[2*n+:2] == 2'h3 && i_segment_level[2*k+:2] == 2'h0)
					|| (i_common_level[2*n+:2] == 2'h0 && i_segment_level[2*k+:2] == 2'h3);
			end
		end
	end
endmodule

// File: sim/segment_lcd_driver_bench.sv
// Self-checking bench for the segment LCD driver
module segment_lcd_driver_bench
	import segment_lcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ===========================================================
	// Stimulus and observation
	logic clock, rstn, tick, hold, read_valid, enabled, polarity, pol;
	logic [1:0] sel;
	logic [5:0] strobes; // on, off, low, high, write, read
	logic [3:0] nib, read_nibble;
	logic [5:0] pointer;
	logic [7:0] common;
	logic [63:0] segment;
	logic [127:0] dots;
	int num_errors, n_compared, c, t, n;
	segment_lcd_driver uut (.i_clock(clock), .i_rstn(rstn), .i_slow_tick(tick),
		.i_freq_select(sel), .i_hold(hold), .i_display_on_instruction(strobes[0]),
		.i_display_off_instruction(strobes[1]), .i_load_pointer_low_part(strobes[2]),
		.i_load_pointer_high_part(strobes[3]), .i_write_entry(strobes[4]),
		.i_read_entry(strobes[5]), .i_nibble(nib), .o_read_nibble(read_nibble),
		.o_read_valid(read_valid), .o_pattern_ram_pointer(pointer),
		.o_display_enabled(enabled), .o_frame_polarity(polarity),
		.o_common_level(common), .o_segment_level(segment));
	lcd_glass_model glass (.i_common_level(common), .i_segment_level(segment), .o_dot_lit(dots));
	// Clock; slow tick every second cycle
	initial begin
		clock = 0;
		forever #10 clock = ~clock;
	end
	initial begin
		tick = 1'b0;
		forever @(negedge clock) tick <= ~tick;
	end
	// Pattern stored in entry k
	function automatic logic [3:0] pat(input int k);
		return 4'(k * 7 + 3);
	endfunction
	task check(input logic [127:0] seen, input logic [127:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask
	// Strobe stays up until the next call, so back-to-back works
	task op(input logic [5:0] s, input logic [3:0] d);
		@(negedge clock);
		strobes = s;
		nib = d;
		@(posedge clock);
	endtask
	// Upper bits of the high nibble are set to prove they are ignored
	task setp(input logic [5:0] p);
		op(6'h04, p[3:0]);
		op(6'h08, {2'h3, p[5:4]});
		#1 check(pointer, p);
	endtask
	// Answer stands for the one cycle after the taking edge, then drops
	task rd(input logic [3:0] e);
		op(6'h20, 4'h0);
		#1 check(read_valid, 1'b1);
		check(read_nibble, e);
		op(6'h00, 4'h0);
		#1 check(read_valid, 1'b0);
	endtask
	// Levels are sampled settled, never in the edge's own time step
	task wchg(output int cnt);
		logic [7:0] prev;
		#1 prev = common;
		cnt = 0;
		while (common === prev && cnt < 5000) begin
			@(posedge clock);
			#1 cnt++;
		end
		if (cnt >= 5000) check(1'b0, 1'b1);
	endtask
	task give_verdict;
		$display("errors %0d compares %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Watchdog: the tests need about 13000 cycles
	initial begin
		#800000;
		num_errors++;
		give_verdict;
	end
	// ===========================================================
	// Tests
	initial begin
		{rstn, hold, sel, strobes, nib, num_errors, n_compared} = '0;
		repeat (20) @(negedge clock);
		check({segment, common, enabled}, '0);
		rstn = 1;
		for (int k = 0; k < 32; k++) begin
			setp(6'(k));
			op(6'h10, pat(k));
		end
		// Past the last entry writes are dropped and reads give zero
		setp(6'h20);
		op(6'h10, 4'hF);
		rd(4'h0);
		for (int k = 0; k < 32; k++) begin
			setp(6'(k));
			rd(pat(k));
		end
		check({segment, common, enabled}, '0);
		@(negedge clock) hold = 1'b1;
		op(6'h01, 4'h0);
		op(6'h00, 4'h0);
		// Each slot must show column n of every entry, slots in turn
		t = -1;
		repeat (9) begin
			wchg(c);
			repeat (3) @(posedge clock);
			#1 for (int i = 0; i < 4; i++) if (common[2*i+:2] == (polarity ? 2'h0 : 2'h3)) n = i;
			if (t >= 0) check(n, (t + 1) % 4);
			if (t >= 0) check(polarity, pol ^ (n == 0));
			t = n;
			pol = polarity;
			for (int k = 0; k < 32; k++) check(dots[k*4+:4], pat(k) & (4'h1 << n));
		end
		// Four slots make one frame of 4 * N slow ticks, two cycles each
		for (int s = 0; s < 4; s++) begin
			@(negedge clock) sel = 2'(s);
			wchg(c);
			wchg(c);
			t = 0;
			repeat (4) begin
				wchg(c);
				t += c;
			end
			check(t, 8 * (64 << s));
		end
		check(enabled, 1'b1);
		op(6'h03, 4'h0);
		op(6'h00, 4'h0);
		repeat (2) @(posedge clock);
		#1 check({segment, common, enabled}, '0);
		give_verdict;
	end
endmodule
bind segment_lcd_driver segment_lcd_asserts chk (.i_clock(i_clock), .i_rstn(i_rstn),
	.i_display_on_instruction(i_display_on_instruction),
	.i_display_off_instruction(i_display_off_instruction),
	.i_load_pointer_low_part(i_load_pointer_low_part),
	.i_load_pointer_high_part(i_load_pointer_high_part), .i_read_entry(i_read_entry),
	.i_nibble(i_nibble), .o_read_valid(o_read_valid),
	.o_pattern_ram_pointer(o_pattern_ram_pointer), .o_display_enabled(o_display_enabled),
	.o_common_level(o_common_level), .o_segment_level(o_segment_level));
